// file: logic/vps_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "vps_map.svh"

// Summary of operation
// - status reserved bits read zero, writes ignored
// - prohibited flag read-only, reset to 0, then loaded from strap on first cycle after release
// - prohibited reads 1 when muxing forbids dual
// - upper-half flag read-only strap, also drives upperHalfRoute
// - upper-half never 1 unless prohibited is 1
// - upper-half 1 means channel A on upper pins
// - each source gated by its enable bit
// - enables reset 0, reserved bits read zero
// - bit 23 enables channel B long field
// - bit 22 enables channel B short field
// - bit 21 enables channel B field-2 vertical
// - bit 20 enables channel B field-1 vertical
// - bit 19 enables channel B sync error
// - bit 18 enables channel B capture complete
// - dual select forced 0 while prohibited
module vps_regs
  import vps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire vps_apb_req_t apbReq,
  output vps_apb_rsp_t apbRsp,
  input wire logic strapProhibitedPin,
  input wire logic strapUpperHalfPin,
  input wire logic [`VPS_SRC_W-1:0] eventPulse,
  output logic irq,
  output logic dualChannelSelect,
  output logic upperHalfRoute
);

  vps_bus_state_t busStateQ;
  vps_strap_t strapMetaQ;
  vps_strap_t strapSyncQ;
  logic capturedQ;
  logic prohibQ;
  logic upperQ;
  logic dualSelQ;
  logic [`VPS_SRC_W-1:0] ieQ;
  logic [`VPS_SRC_W-1:0] pendQ;
  logic [`VPS_DATA_W-1:0] statusWord;
  logic [`VPS_DATA_W-1:0] readMux;
  logic decodeHit;
  logic accessNow;
  logic doWrite;
  logic clearHit;
  localparam logic [`VPS_SRC_W-1:0] SrcLive = `VPS_SRC_MASK;

  // the enable layout must fit one data word
  if (`VPS_SRC_W > `VPS_DATA_W) begin : g_bad_width
    $error("source width exceeds data width");
  end

  // answer one cycle into the access phase; flop-driven pready
  assign accessNow = apbReq.psel & apbReq.penable;
  assign doWrite = apbRsp.pready & accessNow & apbReq.pwrite & ~apbRsp.pslverr;
  assign clearHit = doWrite & (apbReq.paddr == `VPS_OFF_CLEAR);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busStateQ <= VPS_IDLE;
    end else begin
      case (busStateQ)
        VPS_IDLE: begin
          if (accessNow) begin
            busStateQ <= VPS_ANSWER;
          end
        end
        VPS_ANSWER: busStateQ <= VPS_IDLE;
        default: busStateQ <= VPS_IDLE;
      endcase
    end
  end

  // status word: only bits 3 and 2 carry state
  always_comb begin
    statusWord = '0;
    statusWord[`VPS_STAT_PROHIB_BIT] = prohibQ;
    statusWord[`VPS_STAT_UPPER_BIT] = upperQ;
  end

  always_comb begin
    readMux = '0;
    decodeHit = 1'b1;
    case (apbReq.paddr)
      `VPS_OFF_CTRL: readMux[`VPS_CTRL_DUAL_BIT] = dualSelQ;
      `VPS_OFF_STATUS: readMux = statusWord;
      `VPS_OFF_IE: readMux[`VPS_SRC_W-1:0] = ieQ;
      `VPS_OFF_PEND: readMux[`VPS_SRC_W-1:0] = pendQ;
      `VPS_OFF_CLEAR: readMux = '0;
      default: decodeHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      apbRsp <= '0;
    end else if (busStateQ == VPS_IDLE && accessNow) begin
      apbRsp.pready <= 1'b1;
      apbRsp.pslverr <= ~decodeHit;
      apbRsp.prdata <= apbReq.pwrite ? '0 : readMux;
    end else begin
      apbRsp <= '0;
    end
  end

  // straps come from pins: two flops; unreset so they settle while reset is held
  always_ff @(posedge clk) begin
    strapMetaQ <= '{prohibited: strapProhibitedPin, upperHalf: strapUpperHalfPin};
    strapSyncQ <= strapMetaQ;
  end

  // caught once after release; strap changes later are ignored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      capturedQ <= 1'b0;
      prohibQ <= 1'b0;
      upperQ <= 1'b0;
    end else if (!capturedQ && busStateQ == VPS_IDLE) begin
      capturedQ <= 1'b1;
      prohibQ <= strapSyncQ.prohibited;
      upperQ <= strapSyncQ.upperHalf & strapSyncQ.prohibited;
    end
  end

  // no software write path reaches prohibQ or upperQ
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dualSelQ <= `VPS_CTRL_RESET;
    end else if (prohibQ) begin
      dualSelQ <= 1'b0;
    end else if (doWrite && apbReq.paddr == `VPS_OFF_CTRL) begin
      dualSelQ <= apbReq.pwdata[`VPS_CTRL_DUAL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ieQ <= `VPS_SRC_W'(`VPS_IE_RESET);
    end else if (doWrite && apbReq.paddr == `VPS_OFF_IE) begin
      ieQ <= apbReq.pwdata[`VPS_SRC_W-1:0] & `VPS_SRC_MASK;
    end
  end

  // per-source sticky flop; set beats clear in one cycle so no event is lost
  for (genvar k = 0; k < `VPS_SRC_W; k++) begin : g_pend
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pendQ[k] <= 1'b0;
      end else begin
        pendQ[k] <= SrcLive[k] & (eventPulse[k] | (pendQ[k] & ~(clearHit & apbReq.pwdata[k])));
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(pendQ & ieQ);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dualChannelSelect <= 1'b0;
      upperHalfRoute <= 1'b0;
    end else begin
      dualChannelSelect <= dualSelQ & ~prohibQ;
      upperHalfRoute <= upperQ;
    end
  end

  property p_status_reserved;
    @(posedge clk) disable iff (!rst_n)
    (busStateQ == VPS_IDLE && accessNow && !apbReq.pwrite && apbReq.paddr == `VPS_OFF_STATUS)
      |=> (apbRsp.prdata[31:4] == 28'h0 && apbRsp.prdata[1:0] == 2'h0 && apbRsp.pready);
  endproperty
  a_status_reserved: assert property (p_status_reserved) else $error("status reserved bits not zero");

  property p_strap_capture;
    @(posedge clk) disable iff (!rst_n)
    $rose(capturedQ) |-> (prohibQ == $past(strapSyncQ.prohibited));
  endproperty
  a_strap_capture: assert property (p_strap_capture) else $error("prohibited flag not from strap");

  property p_status_prohib_read;
    @(posedge clk) disable iff (!rst_n)
    (busStateQ == VPS_IDLE && accessNow && !apbReq.pwrite && apbReq.paddr == `VPS_OFF_STATUS)
      ##1 $stable(prohibQ) |-> apbRsp.prdata[3] == prohibQ;
  endproperty
  a_status_prohib_read: assert property (p_status_prohib_read) else $error("prohibited flag misread");

  property p_upper_stable;
    @(posedge clk) disable iff (!rst_n)
    (capturedQ && $past(capturedQ)) |-> ($stable(upperQ) && $stable(prohibQ));
  endproperty
  a_upper_stable: assert property (p_upper_stable) else $error("strap flags changed after capture");

  property p_upper_implies;
    @(posedge clk) disable iff (!rst_n)
    upperQ |-> prohibQ;
  endproperty
  a_upper_implies: assert property (p_upper_implies) else $error("upper-half set without prohibited");

  property p_route_follow;
    @(posedge clk) disable iff (!rst_n)
    capturedQ ##1 capturedQ |-> upperHalfRoute == upperQ;
  endproperty
  a_route_follow: assert property (p_route_follow) else $error("routing output wrong");

  property p_irq_gate;
    @(posedge clk) disable iff (!rst_n)
    ##1 irq == |($past(pendQ) & $past(ieQ));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not pending and enable");

  property p_ie_reset;
    @(posedge clk)
    !rst_n |=> (ieQ == '0 && !irq);
  endproperty
  a_ie_reset: assert property (p_ie_reset) else $error("enables not zero after reset");

  property p_ie_reserved;
    @(posedge clk) disable iff (!rst_n)
    (ieQ & ~`VPS_SRC_MASK) == '0;
  endproperty
  a_ie_reserved: assert property (p_ie_reserved) else $error("reserved enable bit set");

  property p_ie_chb_write;
    @(posedge clk) disable iff (!rst_n)
    (doWrite && apbReq.paddr == `VPS_OFF_IE) |=> ieQ[23:18] == $past(apbReq.pwdata[23:18]);
  endproperty
  a_ie_chb_write: assert property (p_ie_chb_write) else $error("enable lost");

  property p_dual_forced;
    @(posedge clk) disable iff (!rst_n)
    prohibQ |=> (!dualSelQ && !dualChannelSelect);
  endproperty
  a_dual_forced: assert property (p_dual_forced) else $error("dual select while prohibited");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
    (clearHit && eventPulse[18]) |=> pendQ[18];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost under clear");

  property p_status_write_ignored;
    @(posedge clk) disable iff (!rst_n)
    (doWrite && apbReq.paddr == `VPS_OFF_STATUS) |=> ($stable(prohibQ) && $stable(upperQ));
  endproperty
  a_status_write_ignored: assert property (p_status_write_ignored) else $error("status written");

  property p_status_upper_read;
    @(posedge clk) disable iff (!rst_n)
    (busStateQ == VPS_IDLE && accessNow && !apbReq.pwrite && apbReq.paddr == `VPS_OFF_STATUS && capturedQ)
      |=> apbRsp.prdata[`VPS_STAT_UPPER_BIT] == $past(upperQ);
  endproperty
  a_status_upper_read: assert property (p_status_upper_read) else $error("upper-half flag misread");

  property p_status_word;
    @(posedge clk) disable iff (!rst_n)
    (busStateQ == VPS_IDLE && accessNow && !apbReq.pwrite && apbReq.paddr == `VPS_OFF_STATUS)
      |=> apbRsp.prdata == {28'h0, $past(prohibQ), $past(upperQ), 2'h0};
  endproperty
  a_status_word: assert property (p_status_word) else $error("status word wrong");

  property p_route_implies;
    @(posedge clk) disable iff (!rst_n)
    upperHalfRoute |-> prohibQ;
  endproperty
  a_route_implies: assert property (p_route_implies) else $error("upper route without prohibited");

  property p_strap_upper_capture;
    @(posedge clk) disable iff (!rst_n)
    $rose(capturedQ) |-> (upperQ == ($past(strapSyncQ.upperHalf) && $past(strapSyncQ.prohibited)));
  endproperty
  a_strap_upper_capture: assert property (p_strap_upper_capture) else $error("upper flag not from strap");

  property p_flags_before_capture;
    @(posedge clk) disable iff (!rst_n)
    !capturedQ |-> (!prohibQ && !upperQ);
  endproperty
  a_flags_before_capture: assert property (p_flags_before_capture) else $error("flag set before capture");

  property p_irq_needs_enable;
    @(posedge clk) disable iff (!rst_n)
    (ieQ == '0) |=> !irq;
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("interrupt with no enable");

  property p_irq_needs_pending;
    @(posedge clk) disable iff (!rst_n)
    (pendQ == '0) |=> !irq;
  endproperty
  a_irq_needs_pending: assert property (p_irq_needs_pending) else $error("interrupt with no pending");

  property p_irq_raise;
    @(posedge clk) disable iff (!rst_n)
    ((pendQ & ieQ) != '0) |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("enabled pending gave no interrupt");

  property p_ie_read;
    @(posedge clk) disable iff (!rst_n)
    (busStateQ == VPS_IDLE && accessNow && !apbReq.pwrite && apbReq.paddr == `VPS_OFF_IE)
      |=> apbRsp.prdata == {8'h00, $past(ieQ)};
  endproperty
  a_ie_read: assert property (p_ie_read) else $error("enable word misread");

  property p_ie_write_mask;
    @(posedge clk) disable iff (!rst_n)
    (doWrite && apbReq.paddr == `VPS_OFF_IE) |=> ieQ == ($past(apbReq.pwdata[`VPS_SRC_W-1:0]) & `VPS_SRC_MASK);
  endproperty
  a_ie_write_mask: assert property (p_ie_write_mask) else $error("enable write not masked");

  property p_ie_hold;
    @(posedge clk) disable iff (!rst_n)
    !(doWrite && apbReq.paddr == `VPS_OFF_IE) |=> $stable(ieQ);
  endproperty
  a_ie_hold: assert property (p_ie_hold) else $error("enable changed without write");

  property p_ctrl_read_prohib;
    @(posedge clk) disable iff (!rst_n)
    (busStateQ == VPS_IDLE && accessNow && !apbReq.pwrite && apbReq.paddr == `VPS_OFF_CTRL && prohibQ)
      |=> !apbRsp.prdata[`VPS_CTRL_DUAL_BIT];
  endproperty
  a_ctrl_read_prohib: assert property (p_ctrl_read_prohib) else $error("dual select reads 1");

  property p_dual_follow;
    @(posedge clk) disable iff (!rst_n)
    !prohibQ |=> (dualChannelSelect == $past(dualSelQ));
  endproperty
  a_dual_follow: assert property (p_dual_follow) else $error("dual select output wrong");

  property p_ctrl_write;
    @(posedge clk) disable iff (!rst_n)
    (!prohibQ && doWrite && apbReq.paddr == `VPS_OFF_CTRL)
      |=> (dualSelQ == $past(apbReq.pwdata[`VPS_CTRL_DUAL_BIT]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("dual select write lost");

  property p_clear_drops;
    @(posedge clk) disable iff (!rst_n)
    (clearHit && apbReq.pwdata[18] && !eventPulse[18]) |=> !pendQ[18];
  endproperty
  a_clear_drops: assert property (p_clear_drops) else $error("pending not cleared");

  property p_pend_sticky;
    @(posedge clk) disable iff (!rst_n)
    (pendQ[18] && !clearHit) |=> pendQ[18];
  endproperty
  a_pend_sticky: assert property (p_pend_sticky) else $error("pending bit dropped");

  property p_pend_reserved;
    @(posedge clk) disable iff (!rst_n)
    (pendQ & ~`VPS_SRC_MASK) == '0;
  endproperty
  a_pend_reserved: assert property (p_pend_reserved) else $error("reserved pending bit set");

  // each channel B source reaches the interrupt once enabled
  for (genvar k = `VPS_IE_CCMP_B_BIT; k <= `VPS_IE_LONG_B_BIT; k++) begin : g_chb_gate
    property p_chb_gate;
      @(posedge clk) disable iff (!rst_n)
      (pendQ[k] && ieQ[k]) |=> irq;
    endproperty
    a_chb_gate: assert property (p_chb_gate) else $error("source lost");
  end

  c_irq_fire: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
  c_clear_race: cover property (@(posedge clk) disable iff (!rst_n) clearHit && |eventPulse);
  c_bad_addr: cover property (@(posedge clk) disable iff (!rst_n) apbRsp.pready && apbRsp.pslverr);
  c_dual_on: cover property (@(posedge clk) disable iff (!rst_n) $rose(dualChannelSelect));
  c_upper_route: cover property (@(posedge clk) disable iff (!rst_n) $rose(upperHalfRoute));

endmodule
`default_nettype wire

// file: logic/vps_map.svh
`ifndef VPS_MAP_SVH
`define VPS_MAP_SVH

`define VPS_ADDR_W 12
`define VPS_DATA_W 32

`define VPS_OFF_CTRL 12'h000
`define VPS_OFF_STATUS 12'h004
`define VPS_OFF_IE 12'h008
`define VPS_OFF_PEND 12'h00c
`define VPS_OFF_CLEAR 12'h010

`define VPS_CTRL_DUAL_BIT 0
`define VPS_STAT_PROHIB_BIT 3
`define VPS_STAT_UPPER_BIT 2

`define VPS_IE_LONG_B_BIT 23
`define VPS_IE_SHORT_B_BIT 22
`define VPS_IE_F2V_B_BIT 21
`define VPS_IE_F1V_B_BIT 20
`define VPS_IE_SERR_B_BIT 19
`define VPS_IE_CCMP_B_BIT 18

`define VPS_SRC_W 24
`define VPS_SRC_MASK 24'hff7cff
`define VPS_IE_RESET 32'h0000_0000
`define VPS_CTRL_RESET 1'b0

`endif

// file: logic/vps_pkg.sv
`default_nettype none
package vps_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } vps_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } vps_apb_rsp_t;

  typedef struct packed {
    logic prohibited;
    logic upperHalf;
  } vps_strap_t;

  typedef enum logic [1:0] {
    VPS_IDLE,
    VPS_ANSWER
  } vps_bus_state_t;
endpackage
`default_nettype wire

// file: sim/video_port_status_irq_enable_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "vps_map.svh"

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end

module video_port_status_irq_enable_tb
  import vps_pkg::*;
;
  logic clk;
  logic rst_n;
  vps_apb_req_t apbReq;
  vps_apb_rsp_t apbRsp;
  logic strapProhibitedPin;
  logic strapUpperHalfPin;
  logic [`VPS_SRC_W-1:0] eventPulse;
  logic irq;
  logic dualChannelSelect;
  logic upperHalfRoute;
  int n_fail;
  int checked;

  vps_regs dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .strapProhibitedPin(strapProhibitedPin),
    .strapUpperHalfPin(strapUpperHalfPin),
    .eventPulse(eventPulse),
    .irq(irq),
    .dualChannelSelect(dualChannelSelect),
    .upperHalfRoute(upperHalfRoute)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic test_done();
    $display("compares %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // request held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int i;
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (apbRsp.pready !== 1'b1 && i < 20);
    if (apbRsp.pready !== 1'b1) begin
      n_fail++;
      test_done();
    end
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, addr, wd, rd, err);
  endtask

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic expErr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, addr, 32'h0000_0000, rd, err);
    `CHK(rd, exp)
    `CHK(err, expErr)
  endtask

  // bounded wait, irq is two edges behind its cause
  task automatic irq_wait(input logic exp);
    int i;
    for (i = 0; i < 6 && irq !== exp; i++) @(posedge clk);
    `CHK(irq, exp)
    if (irq !== exp) begin
      test_done();
    end
  endtask

  // straps must be stable well before reset lets go
  task automatic cfg(input logic p, input logic u, input logic [31:0] expStat);
    @(posedge clk);
    strapProhibitedPin <= p;
    strapUpperHalfPin <= u;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(`VPS_OFF_STATUS, expStat, 1'b0);
    rd_chk(`VPS_OFF_IE, `VPS_IE_RESET, 1'b0);
    `CHK(upperHalfRoute, p & u)
    wr(`VPS_OFF_STATUS, 32'hffff_ffff);
    rd_chk(`VPS_OFF_STATUS, expStat, 1'b0);
    wr(`VPS_OFF_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    `CHK(dualChannelSelect, ~p)
    rd_chk(`VPS_OFF_CTRL, {31'h0000_0000, ~p}, 1'b0);
  endtask

  task automatic t_ie_mask();
    wr(`VPS_OFF_IE, 32'hffff_ffff);
    rd_chk(`VPS_OFF_IE, 32'h00ff_7cff, 1'b0);
    wr(`VPS_OFF_IE, 32'h0000_0000);
    rd_chk(12'h014, 32'h0000_0000, 1'b1);
  endtask

  task automatic t_events();
    int b;
    for (b = 18; b < 24; b++) begin
      @(posedge clk);
      eventPulse <= 24'h00_0001 << b;
      @(posedge clk);
      eventPulse <= '0;
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b0)
      rd_chk(`VPS_OFF_PEND, 32'h1 << b, 1'b0);
      wr(`VPS_OFF_IE, 32'h1 << b);
      irq_wait(1'b1);
      wr(`VPS_OFF_IE, 32'h0000_0000);
      irq_wait(1'b0);
      wr(`VPS_OFF_IE, 32'h1 << b);
      irq_wait(1'b1);
      wr(`VPS_OFF_CLEAR, 32'h1 << b);
      irq_wait(1'b0);
      wr(`VPS_OFF_IE, 32'h0000_0000);
    end
  endtask

  // event lands in the clear's commit cycle: it must survive
  task automatic t_set_wins();
    fork
      wr(`VPS_OFF_CLEAR, 32'h0004_0000);
      begin
        repeat (3) @(posedge clk);
        eventPulse <= 24'h04_0000;
        @(posedge clk);
        eventPulse <= '0;
      end
    join
    rd_chk(`VPS_OFF_PEND, 32'h0004_0000, 1'b0);
    wr(`VPS_OFF_CLEAR, 32'h0004_0000);
    rd_chk(`VPS_OFF_PEND, 32'h0000_0000, 1'b0);
  endtask

  initial begin
    n_fail = 0;
    checked = 0;
    rst_n = 1'b0;
    apbReq = '0;
    strapProhibitedPin = 1'b1;
    strapUpperHalfPin = 1'b1;
    eventPulse = '0;
    cfg(1'b1, 1'b1, 32'h0000_000c);
    t_ie_mask();
    t_events();
    t_set_wins();
    cfg(1'b0, 1'b1, 32'h0000_0000);
    cfg(1'b1, 1'b0, 32'h0000_0008);
    test_done();
  end
endmodule

`default_nettype wire
